// file: verilog/adcs_pkg.sv
// Package of constants and types for the conversion sequencer.
package adcs_pkg;

    // -------------------------------------------------------------------
    // Register addresses on the 8-bit internal bus.
    // -------------------------------------------------------------------
    localparam int          ADDR_W      = 4;
    localparam logic [3:0]  ADDR_RES_HI = 4'h0;  // A hi; B..D every 2.
    localparam logic [3:0]  ADDR_CSR    = 4'h8;
    localparam logic [3:0]  ADDR_TRG    = 4'h9;

    // -------------------------------------------------------------------
    // Field positions and values after reset.
    // -------------------------------------------------------------------
    localparam int          CSR_FLAG    = 7;
    localparam int          CSR_IE      = 6;
    localparam int          CSR_START   = 5;
    localparam int          CSR_SCAN    = 4;
    localparam int          CSR_CKS     = 3;
    localparam int          CSR_GROUP   = 2;
    localparam int          TRG_EN      = 7;
    localparam logic [7:0]  CSR_RESET   = 8'h00;
    localparam logic [7:0]  TRG_RESET   = 8'h7F;
    localparam logic [6:0]  TRG_RSVD    = 7'h7F;
    localparam logic [9:0]  RES_RESET   = 10'h000;
    localparam logic [5:0]  RES_LO_PAD  = 6'h00;
    localparam logic [7:0]  RD_UNMAPPED = 8'h00;
    localparam int          RES_W       = 10;
    localparam logic [9:0]  SAR_MSB     = 10'h200;

    // -------------------------------------------------------------------
    // Timing in states; one state is one clock of 50 ns.
    // -------------------------------------------------------------------
    localparam int SYNC_MIN_0  = 10;
    localparam int SYNC_MIN_1  = 6;
    localparam int SPL_0       = 80;
    localparam int SPL_1       = 40;
    localparam int TOTAL_MIN_0 = 259;
    localparam int TOTAL_MIN_1 = 131;
    localparam int SCAN_NEXT_0 = 256;
    localparam int SCAN_NEXT_1 = 128;
    localparam int CONV_0      = TOTAL_MIN_0 - SYNC_MIN_0 - SPL_0;
    localparam int CONV_1      = TOTAL_MIN_1 - SYNC_MIN_1 - SPL_1;
    localparam int GAP_0       = SCAN_NEXT_0 - SPL_0 - CONV_0;
    localparam int GAP_1       = SCAN_NEXT_1 - SPL_1 - CONV_1;
    localparam int STEP_0      = 16;
    localparam int STEP_1      = 8;
    localparam logic [2:0] PHASE_MAX_0 = 3'h7;
    localparam logic [2:0] PHASE_MAX_1 = 3'h3;

    // -------------------------------------------------------------------
    // Types.
    // -------------------------------------------------------------------
    typedef enum logic [1:0] {ST_IDLE, ST_SYNC, ST_SAMPLE, ST_CONV}
        adcs_phase_e;

    typedef struct packed {
        logic              rd;
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        wdata;
    } adcs_bus_s;

    typedef struct packed {
        adcs_phase_e          st;
        logic                 flag;
        logic                 ie;
        logic                 start;
        logic                 scan;
        logic                 conversion_time_select;
        logic [2:0]           ch;
        logic                 trig_en;
        logic                 trig_prev;
        logic                 armed;
        logic [2:0]           prescale;
        logic [7:0]           cnt;
        logic [4:0]           sub;
        logic [9:0]           trial;
        logic [9:0]           mask;
        logic [1:0]           cur;
        logic [3:0][RES_W-1:0] res;
        logic [7:0]           temp;
        logic [7:0]           rdata;
    } adcs_state_s;

endpackage

// file: verilog/adcs_seq.sv
// Conversion sequencer of a 10-bit successive-approximation converter.
// Function
// - Trigger control is 8 bits, forced to 7F by reset or standby.
// - Trigger enable low ignores the trigger; high starts on falling edge.
// - Low seven bits of trigger control are read-only ones.
// - Upper byte read returns it and copies low byte to holding register.
// - Lower byte read returns the holding register.
// - Ten-bit successive approximation with single and scan modes.
// - Single mode: start bit begins one conversion, reads 1, self-clears.
// - Single completion sets end flag; interrupt raised if enabled.
// - End flag clears only after status read then write of zero.
// - Start bit may be set in the same write as mode or channel.
// - Single completion stores result, sets flag, clears start together.
// - Scan starts at group's first channel; next channel follows at once.
// - Scan repeats until start clears; result goes to its channel.
// - Scan sets flag and restarts at first channel after last channel.
// - Restarted scan resumes from the group's first channel.
// - Sync delay before sampling is 10 to 17 or 6 to 9 states.
// - Sampling takes 80 or 40 states.
// - First conversion takes 259 to 266 or 131 to 134 states.
// - Later scan conversions take exactly 256 or 128 states.
// - Enabled trigger falling edge sets start, as a software start.
// - Group bit and low two bits select channels; inputs map to A to D.
// - Result upper byte holds bits 9..2, lower byte bits 1..0 at 7..6.
// - Reset and standby clear results and stop conversion.
`timescale 1ns/100ps

module adcs_seq
(
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire logic                 ce,
    input  wire logic                 standby,
    input  wire adcs_pkg::adcs_bus_s  bus,
    output logic [7:0]                rdata,
    input  wire logic                 external_trigger_input,
    input  wire logic                 comparator_high,
    output logic [9:0]                sar_trial,
    output logic [2:0]                analog_input_select,
    output logic                      sample_hold,
    output logic                      end_of_conversion_irq
);
    import adcs_pkg::*;

    // -------------------------------------------------------------------
    // Helpers.
    // -------------------------------------------------------------------

    // Picks the count for the selected conversion time.
    function automatic logic [7:0] by_cks(input logic conversion_time_select,
                                          input int   v0,
                                          input int   v1);
        by_cks = conversion_time_select ? v1[7:0] : v0[7:0];
    endfunction

    // Sync delay: minimum plus wait to the next prescaler boundary.
    function automatic logic [7:0] sync_cnt(input logic       conversion_time_select,
                                            input logic [2:0] phase);
        logic [2:0] wait_st;
        wait_st = conversion_time_select ? (PHASE_MAX_1 - (phase & PHASE_MAX_1))
                      : (PHASE_MAX_0 - phase);
        sync_cnt = by_cks(conversion_time_select, SYNC_MIN_0, SYNC_MIN_1) + {5'h00, wait_st};
    endfunction

    adcs_state_s q;
    adcs_state_s d;
    logic        trig_fall;
    logic        start_req;
    logic [1:0]  rsel;
    logic [9:0]  code;

    // -------------------------------------------------------------------
    // Next-state logic.
    // -------------------------------------------------------------------

    // Bus access, trigger, and conversion sequencing.
    always_comb
    begin
        d         = q;
        start_req = 1'b0;
        code      = q.trial;
        rsel      = bus.addr[2:1];
        d.prescale  = q.prescale + 3'h1;
        d.trig_prev = external_trigger_input;
        trig_fall   = q.trig_en && q.trig_prev
                      && !external_trigger_input;

        // Register reads; data is presented the next cycle.
        if (bus.rd)
        begin
            if (!bus.addr[3] && !bus.addr[0])
            begin
                d.rdata = q.res[rsel][9:2];
                d.temp  = {q.res[rsel][1:0], RES_LO_PAD};
            end
            else if (!bus.addr[3])
                d.rdata = q.temp;
            else if (bus.addr == ADDR_CSR)
            begin
                d.rdata = {q.flag, q.ie, q.start, q.scan, q.conversion_time_select, q.ch};
                if (q.flag)
                    d.armed = 1'b1;
            end
            else if (bus.addr == ADDR_TRG)
                d.rdata = {q.trig_en, TRG_RSVD};
            else
                d.rdata = RD_UNMAPPED;
        end

        // Register writes; a zero start bit halts conversion.
        if (bus.wr && bus.addr == ADDR_CSR)
        begin
            d.ie    = bus.wdata[CSR_IE];
            d.scan  = bus.wdata[CSR_SCAN];
            d.conversion_time_select   = bus.wdata[CSR_CKS];
            d.ch    = bus.wdata[CSR_GROUP:0];
            d.start = bus.wdata[CSR_START];
            if (bus.wdata[CSR_START] && !q.start)
                start_req = 1'b1;
            if (!bus.wdata[CSR_START])
                d.st = ST_IDLE;
            if (!bus.wdata[CSR_FLAG] && q.armed)
            begin
                d.flag  = 1'b0;
                d.armed = 1'b0;
            end
        end
        else if (bus.wr && bus.addr == ADDR_TRG)
            d.trig_en = bus.wdata[TRG_EN];

        // External trigger behaves as a software start.
        if (trig_fall && !d.start)
        begin
            d.start   = 1'b1;
            start_req = 1'b1;
        end

        // A scan start begins at the group's first channel; a single start at the selected channel.
        if (start_req)
        begin
            d.st  = ST_SYNC;
            d.cnt = sync_cnt(d.conversion_time_select, q.prescale);
            d.cur = d.scan ? 2'h0 : d.ch[1:0];
        end
        else if (q.start && d.start)
        begin
            case (q.st)
                ST_SYNC:
                begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h01)
                    begin
                        d.st  = ST_SAMPLE;
                        d.cnt = by_cks(q.conversion_time_select, SPL_0, SPL_1);
                    end
                end
                ST_SAMPLE:
                begin
                    d.cnt = q.cnt - 8'h01;
                    if (q.cnt == 8'h01)
                    begin
                        d.st    = ST_CONV;
                        d.cnt   = by_cks(q.conversion_time_select, CONV_0, CONV_1);
                        d.trial = SAR_MSB;
                        d.mask  = SAR_MSB;
                        d.sub   = 5'(by_cks(q.conversion_time_select, STEP_0, STEP_1));
                    end
                end
                ST_CONV:
                begin
                    d.cnt = q.cnt - 8'h01;
                    d.sub = q.sub - 5'h01;
                    // One bit is decided per step, highest first.
                    if (q.sub == 5'h01 && q.mask != 10'h000)
                    begin
                        code    = comparator_high ? q.trial
                                                  : (q.trial & ~q.mask);
                        d.mask  = q.mask >> 1;
                        d.trial = code | (q.mask >> 1);
                        d.sub   = 5'(by_cks(q.conversion_time_select, STEP_0, STEP_1));
                    end
                    if (q.cnt == 8'h01)
                    begin
                        d.res[q.cur] = q.trial;
                        if (!q.scan)
                        begin
                            d.flag  = 1'b1;
                            d.start = 1'b0;
                            d.st    = ST_IDLE;
                        end
                        else
                        begin
                            d.st  = ST_SYNC;
                            d.cnt = by_cks(q.conversion_time_select, GAP_0, GAP_1);
                            if (q.cur == q.ch[1:0])
                            begin
                                d.flag = 1'b1;
                                d.cur  = 2'h0;
                            end
                            else
                                d.cur = q.cur + 2'h1;
                        end
                    end
                end
                default:
                    d.st = ST_IDLE;
            endcase
        end

        // Standby forces the same state as reset.
        if (standby)
            d = '0;
    end

    // -------------------------------------------------------------------
    // State register.
    // -------------------------------------------------------------------

    // Reset clears everything; clock enable low freezes all state.
    always_ff @(posedge clk)
    begin
        if (rst)
            q <= '0;
        else if (ce)
            q <= d;
    end

    // -------------------------------------------------------------------
    // Outputs.
    // -------------------------------------------------------------------

    // Data outputs from flops; request follows the flag and enable.
    assign rdata                 = q.rdata;
    assign sar_trial             = q.trial;
    assign analog_input_select   = {q.ch[CSR_GROUP], q.cur};
    assign sample_hold           = (q.st == ST_SAMPLE);
    assign end_of_conversion_irq = q.flag & q.ie;

    // -------------------------------------------------------------------
    // Assertions.
    // -------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_trg_reserved_ones: assert property (
        $past(ce && !standby && bus.rd && bus.addr == ADDR_TRG)
        |-> rdata[6:0] == TRG_RSVD)
        else $error("Trigger control low bits not all ones.");

    a_low_byte_temp: assert property (
        $past(ce && !standby && bus.rd && !bus.addr[3] && bus.addr[0])
        |-> rdata == $past(q.temp))
        else $error("Low byte read did not return holding register.");

    a_high_copies_low: assert property (
        $past(ce && !standby && bus.rd && !bus.addr[3] && !bus.addr[0])
        |-> q.temp[5:0] == RES_LO_PAD
            && rdata == $past(q.res[rsel][9:2]))
        else $error("Upper byte read path wrong.");

    a_single_finish: assert property (
        $past(ce && !standby && q.start && !q.scan && q.st == ST_CONV
              && q.cnt == 8'h01 && !(bus.wr && bus.addr == ADDR_CSR))
        |-> q.flag && !q.start && q.st == ST_IDLE)
        else $error("Single completion did not stop and flag.");

    a_trig_disabled: assert property (
        $past(ce && !q.trig_en && !q.start && !bus.wr)
        |-> !q.start)
        else $error("Start set with trigger disabled.");

    a_sync_bounds: assert property (
        ($past(q.st) == ST_IDLE && q.st == ST_SYNC)
        |-> (q.conversion_time_select ? (q.cnt >= 8'h06 && q.cnt <= 8'h09)
                   : (q.cnt >= 8'h0A && q.cnt <= 8'h11)))
        else $error("Sync delay out of range.");

    a_result_only_done: assert property (
        (q.res != $past(q.res) && !$past(standby))
        |-> $past(q.st == ST_CONV && q.cnt == 8'h01))
        else $error("Result changed without completion.");

    a_flag_clear_seq: assert property (
        $fell(q.flag) && !$past(standby)
        |-> $past(q.armed && bus.wr && bus.addr == ADDR_CSR))
        else $error("End flag cleared without read then write.");

    a_sample_length: assert property (
        ($rose(sample_hold) && q.conversion_time_select) |-> q.cnt == 8'h28)
        else $error("Sampling length wrong.");

    // Interrupt stands in the cycle after a single completion.
    a_irq_on_finish: assert property (
        $past(ce && !standby && q.start && !q.scan && q.ie
              && q.st == ST_CONV && q.cnt == 8'h01
              && !(bus.wr && bus.addr == ADDR_CSR))
        |-> end_of_conversion_irq)
        else $error("Interrupt not raised at single completion.");

    // The gap makes every later scan conversion the fixed length.
    a_scan_gap_len: assert property (
        $past(ce && !standby && q.start && q.scan
              && q.st == ST_CONV && q.cnt == 8'h01
              && !(bus.wr && bus.addr == ADDR_CSR))
        |-> q.st == ST_SYNC && q.cnt == (q.conversion_time_select ? 8'h03 : 8'h07))
        else $error("Scan gap before next channel wrong.");

    a_scan_first_chan: assert property (
        ($past(q.st) == ST_IDLE && q.st == ST_SYNC && q.scan)
        |-> q.cur == 2'h0)
        else $error("Scan did not start at first channel.");

    a_single_chan: assert property (
        ($past(q.st) == ST_IDLE && q.st == ST_SYNC && !q.scan)
        |-> q.cur == q.ch[1:0])
        else $error("Single conversion on wrong channel.");

    // A trigger edge in the same cycle restarts, so it is left out.
    a_stop_goes_idle: assert property (
        $past(ce && !standby && !trig_fall && bus.wr
              && bus.addr == ADDR_CSR && !bus.wdata[CSR_START])
        |-> q.st == ST_IDLE && !q.start)
        else $error("Clearing start did not halt conversion.");

    a_trg_write: assert property (
        $past(ce && !standby && bus.wr && bus.addr == ADDR_TRG)
        |-> q.trig_en == $past(bus.wdata[TRG_EN]))
        else $error("Trigger enable write not taken.");

    a_standby_clear: assert property (
        $past(ce && standby) |-> q.res == '0 && !q.start && !q.trig_en)
        else $error("Standby did not clear results and start.");

    a_trig_starts: assert property (
        $past(ce && !standby && trig_fall && !q.start)
        |-> q.start && q.st == ST_SYNC)
        else $error("Enabled trigger fall did not start.");

    c_single_done: cover property (
        $past(q.st == ST_CONV) && $fell(q.start) && q.flag);
    c_scan_wrap: cover property (
        q.scan && $rose(q.flag) && q.start);
    c_trig_start: cover property (
        trig_fall && ce && !q.start);
    c_stop_abort: cover property (
        q.st == ST_CONV && bus.wr && bus.addr == ADDR_CSR
        && !bus.wdata[CSR_START]);

endmodule

// file: verif/adcs_analog_model.sv
// Behavioural analog source and comparator facing the sequencer.
`timescale 1ns/100ps

module adcs_analog_model
(
    input  wire logic [2:0] analog_input_select,
    input  wire logic [9:0] sar_trial,
    output logic            comparator_high
);
    import adcs_pkg::*;

    logic [9:0] level;

    // Each input holds a fixed level built from its own index.
    assign level = {analog_input_select, 7'h5A};

    // The comparator is high while the input is at or above the trial.
    assign comparator_high = (level >= sar_trial);
endmodule

// file: verif/tb_adcs_seq.sv
// Self-checking testbench of the conversion sequencer.
`timescale 1ns/100ps

module tb_adcs_seq;
    import adcs_pkg::*;

    logic            clk;
    logic            rst;
    logic            ce;
    logic            standby;
    logic            ext_trig;
    logic            cmp_high;
    logic            irq;
    logic            sh;
    adcs_bus_s       bus;
    logic [7:0]      rdata;
    logic [9:0]      trial;
    logic [2:0]      sel;
    logic [7:0]      d;
    int              err_total;
    int              cmp_count;
    int              n;
    int              m;
    int              sh_cnt;

    // Clock of 50 ns.
    initial clk = 1'b0;
    always #25 clk = ~clk;

    // Counts the states in which the sample-and-hold is closed.
    always @(posedge clk)
    begin
        if (rst)
            sh_cnt <= 0;
        else if (sh)
            sh_cnt <= sh_cnt + 1;
    end

    adcs_seq u_adcs_seq
    (
        .clk                    (clk),
        .rst                    (rst),
        .ce                     (ce),
        .standby                (standby),
        .bus                    (bus),
        .rdata                  (rdata),
        .external_trigger_input (ext_trig),
        .comparator_high        (cmp_high),
        .sar_trial              (trial),
        .analog_input_select    (sel),
        .sample_hold            (sh),
        .end_of_conversion_irq  (irq)
    );

    adcs_analog_model u_adcs_analog_model
    (
        .analog_input_select (sel),
        .sar_trial           (trial),
        .comparator_high     (cmp_high)
    );

    // Level that the analog model shows on an input.
    function automatic logic [9:0] lvl(input logic [2:0] s);
        return {s, 7'h5A};
    endfunction

    // Compares one value and counts the outcome.
    task automatic chk(input string nm, input logic [9:0] seen,
                       input logic [9:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // One write strobe; the edge after raising it takes the access.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        bus.wr    <= 1'b1;
        bus.addr  <= a;
        bus.wdata <= v;
        @(posedge clk);
        bus.wr    <= 1'b0;
        #1;
    endtask

    // One read strobe; the data stands just after the taking edge.
    task automatic rchk(input string nm, input logic [3:0] a,
                        input logic [7:0] e);
        @(posedge clk);
        bus.rd   <= 1'b1;
        bus.addr <= a;
        @(posedge clk);
        bus.rd   <= 1'b0;
        #1;
        d = rdata;
        chk(nm, {2'b00, d}, {2'b00, e});
    endtask

    // Waits for the interrupt (w = 0) or for an input select value.
    task automatic wait_for(input int w, input logic [2:0] v,
                            output int k);
        k = 0;
        while (!((w == 0) ? (irq === 1'b1) : (sel === v)) && k < 400)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        if (k >= 400)
        begin
            err_total++;
            close_out();
        end
    endtask

    // Main sequence.
    initial
    begin
        rst = 1'b1;
        ce = 1'b1;
        standby = 1'b0;
        ext_trig = 1'b1;
        bus = '0;
        err_total = 0;
        cmp_count = 0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        rchk("trg_reset", ADDR_TRG, 8'h7F);
        rchk("csr_reset", ADDR_CSR, 8'h00);
        rchk("res_a_reset", 4'h0, 8'h00);
        rchk("unmapped", 4'hA, 8'h00);
        wr(ADDR_TRG, 8'hFF);
        rchk("trg_on", ADDR_TRG, 8'hFF);
        wr(ADDR_TRG, 8'h00);
        rchk("trg_off", ADDR_TRG, 8'h7F);
        // Single conversion of input 1, short timing, interrupt on.
        wr(ADDR_CSR, 8'h69);
        rchk("start_reads_one", ADDR_CSR, 8'h69);
        wait_for(0, 3'h0, n);
        chk("single_len", 10'(n >= 129 && n <= 132), 10'h001);
        chk("sample_states", 10'(sh_cnt), 10'h028);
        rchk("b_hi", 4'h2, 8'(lvl(3'h1) >> 2));
        rchk("a_hi", 4'h0, 8'h00);
        rchk("b_lo_hold", 4'h3, 8'h00);
        rchk("b_hi_again", 4'h2, 8'(lvl(3'h1) >> 2));
        rchk("b_lo", 4'h3, 8'({lvl(3'h1) & 10'h003, 6'h00}));
        // A zero write without the status read first leaves the flag.
        wr(ADDR_CSR, 8'h49);
        rchk("flag_kept", ADDR_CSR, 8'hC9);
        wr(ADDR_CSR, 8'h49);
        rchk("flag_cleared", ADDR_CSR, 8'h49);
        chk("irq_low", {9'h000, irq}, 10'h000);
        // Trigger falls while disabled, then while enabled.
        wr(ADDR_CSR, 8'h48);
        @(posedge clk);
        ext_trig <= 1'b0;
        repeat (4) @(posedge clk);
        ext_trig <= 1'b1;
        rchk("trig_ignored", ADDR_CSR, 8'h48);
        wr(ADDR_TRG, 8'h80);
        @(posedge clk);
        ext_trig <= 1'b0;
        repeat (3) @(posedge clk);
        rchk("trig_start", ADDR_CSR, 8'h68);
        wait_for(0, 3'h0, n);
        rchk("a_hi_trig", 4'h0, 8'(lvl(3'h0) >> 2));
        @(posedge clk);
        ext_trig <= 1'b1;
        rchk("trig_done", ADDR_CSR, 8'hC8);
        wr(ADDR_CSR, 8'h08);
        // Scan of inputs 4 and 5 with the short timing.
        wr(ADDR_CSR, 8'h3D);
        wait_for(1, 3'h5, n);
        chk("scan_first", 10'(n >= 131 && n <= 134), 10'h001);
        wait_for(1, 3'h4, m);
        chk("scan_next", 10'(m), 10'h080);
        rchk("scan_flag", ADDR_CSR, 8'hBD);
        wait_for(1, 3'h5, m);
        chk("scan_repeat", 10'(m + 2), 10'h080);
        wr(ADDR_CSR, 8'h1D);
        repeat (20) @(posedge clk);
        rchk("scan_stopped", ADDR_CSR, 8'h1D);
        wr(ADDR_CSR, 8'h3D);
        repeat (20) @(posedge clk);
        #1;
        chk("restart_first", {7'h00, sel}, 10'h004);
        wr(ADDR_CSR, 8'h1D);
        rchk("a_hi_scan", 4'h0, 8'(lvl(3'h4) >> 2));
        rchk("b_hi_scan", 4'h2, 8'(lvl(3'h5) >> 2));
        rchk("b_lo_scan", 4'h3, 8'({lvl(3'h5) & 10'h003, 6'h00}));
        // An aborted single conversion leaves its result alone.
        wr(ADDR_CSR, 8'h2A);
        repeat (50) @(posedge clk);
        wr(ADDR_CSR, 8'h0A);
        repeat (200) @(posedge clk);
        rchk("c_hi_abort", 4'h4, 8'h00);
        // Standby forces the reset state.
        @(posedge clk);
        standby <= 1'b1;
        @(posedge clk);
        standby <= 1'b0;
        rchk("csr_standby", ADDR_CSR, 8'h00);
        rchk("trg_standby", ADDR_TRG, 8'h7F);
        rchk("b_hi_standby", 4'h2, 8'h00);
        // A write while the clock enable is low is not taken.
        @(posedge clk);
        ce <= 1'b0;
        wr(ADDR_TRG, 8'h80);
        @(posedge clk);
        ce <= 1'b1;
        rchk("trg_frozen", ADDR_TRG, 8'h7F);
        close_out();
    end
endmodule
